// ===== hd_bus_pkg.sv
/*
  Shared constants, frame layout and state codes for the half-duplex
  multi-drop network node and its far-end master.
  Assumes one common clock for both ends and a byte-level line model.
*/
package hd_bus_pkg;
  // Clock and timing
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam real SLOT_S = 0.1;
  localparam int unsigned SLOT_CYC = $rtoi(SLOT_S * CLK_HZ);
  localparam int unsigned TIMEOUT_DEF = 1024;
  localparam int unsigned BACKOFF_DEF = 64;
  localparam logic [7:0] IDLE_CYC = 8'h08;

  // Frame layout: at-sign, id, header, argument, check, terminator
  localparam logic [2:0] FRAME_LEN = 3'h6;
  localparam int F_ID = 1;
  localparam int F_HDR = 2;
  localparam int F_ARG = 3;
  localparam int F_FCS = 4;
  localparam int F_TERM = 5;
  localparam logic [7:0] CH_AT = 8'h40;
  localparam logic [7:0] CH_TERM = 8'h2A;
  localparam logic [7:0] HDR_TOKEN = 8'h54;
  localparam logic [7:0] HDR_FERR = 8'h45;

  // Access modes
  localparam logic [1:0] MODE_SENSE = 2'h0;
  localparam logic [1:0] MODE_TOKEN = 2'h1;
  localparam logic [1:0] MODE_GRANT = 2'h2;

  // Register word indices, node end
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_NODE_ID = 3'h1;
  localparam logic [2:0] REG_CMD = 3'h2;
  localparam logic [2:0] REG_STATUS = 3'h3;
  localparam logic [2:0] REG_REPLY = 3'h4;
  localparam logic [2:0] REG_DATA = 3'h5;
  // Register word indices, master end
  localparam logic [2:0] HREG_CTRL = 3'h0;
  localparam logic [2:0] HREG_CMD = 3'h1;
  localparam logic [2:0] HREG_STATUS = 3'h2;
  localparam logic [2:0] HREG_REPLY = 3'h3;

  // Field positions
  localparam int CTRL_GO = 8;
  localparam int CTRL_FIXED = 4;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_ERR = 2;
  localparam int ST_TOKEN = 3;
  localparam int ST_FERR = 4;
  localparam int ST_REFUSED = 5;

  // Reset values
  localparam logic [7:0] RST_NODE_ID = 8'h01;
  localparam logic [7:0] RST_HOST_ID = 8'hF0;
  localparam logic [7:0] RST_FIRST_ID = 8'h01;

  typedef logic [5:0][7:0] frame_t;

  typedef enum logic [4:0] {
    PH_IDLE = 5'b00001,
    PH_ARB = 5'b00010,
    PH_SEND = 5'b00100,
    PH_RWAIT = 5'b01000,
    PH_BACK = 5'b10000
  } phase_t;

  function automatic logic [7:0] fcs(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c,
                                     input logic [7:0] d);
    fcs = a ^ b ^ c ^ d;
  endfunction : fcs

  function automatic frame_t frame(input logic [7:0] id, input logic [7:0] hdr, input logic [7:0] arg);
    frame = {CH_TERM, fcs(CH_AT, id, hdr, arg), arg, hdr, id, CH_AT};
  endfunction : frame
endpackage : hd_bus_pkg

// ===== hd_link_if.sv
/*
  Shared half-duplex line between the node and the far-end master.
  Assumes both ends run on one clock; the line level is resolved here.
*/
`timescale 1ns/100ps
interface hd_link_if;
  logic dev_tx_oe_n;
  logic dev_tx_stb;
  logic [7:0] dev_tx_byte;
  logic host_tx_oe_n;
  logic host_tx_stb;
  logic [7:0] host_tx_byte;
  logic grant;
  logic line_driven;
  logic line_stb;
  logic line_collision;
  logic [7:0] line_byte;

  assign line_driven = !dev_tx_oe_n || !host_tx_oe_n;
  assign line_collision = !dev_tx_oe_n && !host_tx_oe_n;
  assign line_stb = (!dev_tx_oe_n && dev_tx_stb) || (!host_tx_oe_n && host_tx_stb);
  assign line_byte = !dev_tx_oe_n ? dev_tx_byte : (!host_tx_oe_n ? host_tx_byte : 8'hFF);

  modport dev (
    output dev_tx_oe_n, dev_tx_stb, dev_tx_byte,
    input line_driven, line_stb, line_byte, grant
  );
  modport host (
    output host_tx_oe_n, host_tx_stb, host_tx_byte, grant,
    input line_driven, line_stb, line_byte
  );
endinterface : hd_link_if

// ===== hd_link_monitor.sv
/*
  Checker for the shared half-duplex line between node and master.
  Assumes one clock and takes the interface signals as plain inputs.
*/
`timescale 1ns/100ps
module hd_link_monitor
  import hd_bus_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Line
  input wire logic dev_tx_oe_n,
  input wire logic dev_tx_stb,
  input wire logic [7:0] dev_tx_byte,
  input wire logic host_tx_oe_n,
  input wire logic host_tx_stb,
  input wire logic [7:0] host_tx_byte,
  input wire logic grant,
  input wire logic line_driven
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic [7:0] idle;
  logic [7:0] idle_at;
  // Idle run length before a node enable
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      idle <= 8'h00;
      idle_at <= 8'h00;
    end else begin
      idle <= line_driven ? 8'h00 : (idle == 8'hFF ? idle : idle + 8'h01);
      if ($fell(dev_tx_oe_n)) idle_at <= idle;
    end
  end
  property p_one_drv;
    !(!dev_tx_oe_n && !host_tx_oe_n);
  endproperty
  a_one_drv: assert property (p_one_drv) else $error("both drivers on");
  property p_dev_stb;
    dev_tx_stb |-> !dev_tx_oe_n;
  endproperty
  a_dev_stb: assert property (p_dev_stb) else $error("node byte while released");
  property p_host_stb;
    host_tx_stb |-> !host_tx_oe_n;
  endproperty
  a_host_stb: assert property (p_host_stb) else $error("master byte while released");
  property p_dev_frame;
    $fell(dev_tx_oe_n) |=> (dev_tx_stb && dev_tx_byte == CH_AT) ##1 dev_tx_stb [*4]
      ##1 (dev_tx_stb && dev_tx_byte == CH_TERM) ##1 (dev_tx_oe_n && !dev_tx_stb);
  endproperty
  a_dev_frame: assert property (p_dev_frame) else $error("node frame shape");
  property p_host_frame;
    $fell(host_tx_oe_n) |=> (host_tx_stb && host_tx_byte == CH_AT) ##1 host_tx_stb [*4]
      ##1 (host_tx_stb && host_tx_byte == CH_TERM) ##1 host_tx_oe_n;
  endproperty
  a_host_frame: assert property (p_host_frame) else $error("master frame shape");
  property p_dev_fcs;
    $fell(dev_tx_oe_n) |-> ##5
      (dev_tx_byte == (CH_AT ^ $past(dev_tx_byte, 1) ^ $past(dev_tx_byte, 2) ^ $past(dev_tx_byte, 3)));
  endproperty
  a_dev_fcs: assert property (p_dev_fcs) else $error("node check field");
  property p_host_fcs;
    $fell(host_tx_oe_n) |-> ##5
      (host_tx_byte == (CH_AT ^ $past(host_tx_byte, 1) ^ $past(host_tx_byte, 2) ^ $past(host_tx_byte, 3)));
  endproperty
  a_host_fcs: assert property (p_host_fcs) else $error("master check field");
  property p_dev_idle;
    $fell(dev_tx_oe_n) ##2 (dev_tx_byte == RST_HOST_ID) |-> idle_at >= IDLE_CYC;
  endproperty
  a_dev_idle: assert property (p_dev_idle) else $error("node command on busy line");
  c_dev_frame: cover property ($fell(dev_tx_oe_n));
  c_host_frame: cover property ($fell(host_tx_oe_n));
  c_grant: cover property ($rose(grant));
endmodule : hd_link_monitor

// ===== hd_master.sv
/*
  Far-end master: direct commands with reply check, backoff and retry,
  token master and grant-line sequencer, behind an Avalon-MM slave.
  Assumes the node shares the clock and the line interface.
*/
`timescale 1ns/100ps
module hd_master
  import hd_bus_pkg::*;
#(
  parameter logic [7:0] HOST_ID = RST_HOST_ID,
  parameter logic [7:0] FIRST_ID = RST_FIRST_ID,
  parameter int unsigned NODES = 4,
  parameter int unsigned SLOT_CYC_P = SLOT_CYC,
  parameter int unsigned TIMEOUT_CYC = TIMEOUT_DEF,
  parameter int unsigned BACKOFF_CYC = BACKOFF_DEF
)(
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Avalon-MM slave
  input wire logic [2:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Network
  hd_link_if.host link
);
  typedef struct packed {
    phase_t ph;
    logic [1:0] mode;
    logic fixed;
    logic [7:0] tgt, hdr, arg;
    logic pend, ptok, done, err, refused, tok_out, grant;
    logic [7:0] rep_id, rep_hdr, rep_data, tries, idx;
    logic waitreq, oe_n, stb, is_cmd;
    logic [7:0] tx_byte;
    frame_t txb;
    frame_t rxb;
    logic [2:0] tx_idx, rx_cnt;
    logic [7:0] idle_cnt;
    logic [31:0] tmo, slot, rdata;
  } host_t;

  localparam host_t HOST_RST = '{ph: PH_IDLE, waitreq: 1'b1, oe_n: 1'b1, default: '0};

  host_t s;
  host_t next_s;
  logic rx_full;
  logic fcs_ok;
  logic quiet;
  logic [7:0] idx_next;

  assign rx_full = (s.rx_cnt == FRAME_LEN) && (s.rxb[F_TERM] == CH_TERM);
  assign fcs_ok = fcs(CH_AT, s.rxb[F_ID], s.rxb[F_HDR], s.rxb[F_ARG]) == s.rxb[F_FCS];
  assign quiet = s.idle_cnt == IDLE_CYC;
  assign idx_next = (s.idx == 8'(NODES - 1)) ? 8'h00 : s.idx + 8'h01;

  always_comb begin
    next_s = s;
    next_s.stb = 1'b0;
    // Bus slave, one wait cycle
    next_s.waitreq = 1'b1;
    if ((read || write) && s.waitreq) begin
      next_s.waitreq = 1'b0;
      unique case (address)
        HREG_CTRL: next_s.rdata = {27'h0, s.fixed, 2'h0, s.mode};
        HREG_STATUS: next_s.rdata = {8'h0, s.idx, s.tries, 2'h0, s.refused, 1'b0, s.tok_out, s.err, s.done, s.pend};
        HREG_REPLY: next_s.rdata = {8'h0, s.rep_data, s.rep_hdr, s.rep_id};
        default: next_s.rdata = 32'h0;
      endcase
    end
    if (write && !s.waitreq) begin
      unique case (address)
        HREG_CTRL: begin
          next_s.mode = writedata[1:0];
          next_s.fixed = writedata[CTRL_FIXED];
        end
        HREG_CMD: begin
          if (s.pend || s.mode == MODE_TOKEN) begin
            next_s.refused = 1'b1;
          end else begin
            {next_s.arg, next_s.hdr, next_s.tgt} = writedata[23:0];
            next_s.pend = 1'b1;
            next_s.ptok = 1'b0;
            next_s.tries = 8'h00;
            next_s.done = 1'b0;
            next_s.err = 1'b0;
          end
        end
        HREG_STATUS: begin
          if (writedata[ST_DONE]) next_s.done = 1'b0;
          if (writedata[ST_ERR]) next_s.err = 1'b0;
          if (writedata[ST_REFUSED]) next_s.refused = 1'b0;
        end
        default: ;
      endcase
    end
    // Receive frames from the line
    if (s.rx_cnt == FRAME_LEN) begin
      next_s.rx_cnt = 3'h0;
    end else if (link.line_stb && s.oe_n) begin
      if (s.rx_cnt == 3'h0) begin
        if (link.line_byte == CH_AT) next_s.rx_cnt = 3'h1;
      end else begin
        next_s.rxb[s.rx_cnt] = link.line_byte;
        next_s.rx_cnt = s.rx_cnt + 3'h1;
      end
    end
    next_s.idle_cnt = link.line_driven ? 8'h00 : (quiet ? s.idle_cnt : s.idle_cnt + 8'h01);
    // Slot timer and grant sequencer
    next_s.slot = (s.slot == 32'(SLOT_CYC_P - 1)) ? 32'h0 : s.slot + 32'h1;
    if (s.mode == MODE_GRANT && s.slot == 32'(SLOT_CYC_P - 1)) next_s.idx = idx_next;
    next_s.grant = (s.mode == MODE_GRANT) && (s.idx == 8'h00);
    // Token master
    if (s.mode == MODE_TOKEN && !s.pend && s.ph == PH_IDLE) begin
      if (!s.tok_out) begin
        {next_s.tgt, next_s.hdr, next_s.arg} = {FIRST_ID + s.idx, HDR_TOKEN, 8'h01};
        next_s.pend = 1'b1;
        next_s.ptok = 1'b1;
      end else if (s.fixed && s.slot == 32'(SLOT_CYC_P - 1)) begin
        {next_s.tgt, next_s.hdr, next_s.arg} = {FIRST_ID + s.idx, HDR_TOKEN, 8'h00};
        next_s.pend = 1'b1;
        next_s.ptok = 1'b1;
      end
    end
    unique case (s.ph)
      PH_IDLE, PH_ARB: begin
        if (rx_full && fcs_ok && s.rxb[F_ID] == HOST_ID && s.rxb[F_HDR] == HDR_TOKEN) begin
          next_s.tok_out = 1'b0;
          next_s.idx = idx_next;
          next_s.txb = frame(HOST_ID, HDR_TOKEN, s.rxb[F_ARG]);
          next_s.is_cmd = 1'b0;
          next_s.oe_n = 1'b0;
          next_s.tx_idx = 3'h0;
          next_s.ph = PH_SEND;
        end else if (s.ph == PH_IDLE) begin
          if (s.pend) next_s.ph = PH_ARB;
        end else if (quiet && (s.mode == MODE_SENSE || s.ptok || (s.mode == MODE_GRANT && !s.grant))) begin
          next_s.txb = frame(s.tgt, s.hdr, s.arg);
          next_s.is_cmd = 1'b1;
          next_s.oe_n = 1'b0;
          next_s.tx_idx = 3'h0;
          next_s.ph = PH_SEND;
        end
      end
      PH_SEND: begin
        if (s.tx_idx != FRAME_LEN) begin
          next_s.stb = 1'b1;
          next_s.tx_byte = s.txb[s.tx_idx];
          next_s.tx_idx = s.tx_idx + 3'h1;
        end else begin
          next_s.oe_n = 1'b1;
          next_s.tmo = 32'(TIMEOUT_CYC);
          next_s.ph = s.is_cmd ? PH_RWAIT : (s.pend ? PH_ARB : PH_IDLE);
        end
      end
      PH_RWAIT: begin
        next_s.tmo = s.tmo - 32'h1;
        if (rx_full && fcs_ok && s.rxb[F_ID] == s.tgt && s.rxb[F_HDR] == s.hdr) begin
          next_s.pend = 1'b0;
          next_s.ph = PH_IDLE;
          if (s.ptok) begin
            next_s.tok_out = s.arg[0];
            next_s.slot = 32'h0;
            if (!s.arg[0]) next_s.idx = idx_next;
          end else begin
            next_s.done = 1'b1;
            {next_s.rep_data, next_s.rep_hdr, next_s.rep_id} = {s.rxb[F_ARG], s.rxb[F_HDR], s.rxb[F_ID]};
          end
        end else if (rx_full || s.tmo == 32'h0) begin
          next_s.err = !s.ptok;
          next_s.tries = s.tries + 8'h01;
          next_s.tmo = 32'(BACKOFF_CYC);
          next_s.ph = PH_BACK;
        end
      end
      PH_BACK: begin
        next_s.tmo = s.tmo - 32'h1;
        if (s.tmo == 32'h0) next_s.ph = PH_ARB;
      end
      default: next_s.ph = PH_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      s <= HOST_RST;
    end else begin
      s <= next_s;
    end
  end

  assign readdata = s.rdata;
  assign waitrequest = s.waitreq;
  assign link.host_tx_oe_n = s.oe_n;
  assign link.host_tx_stb = s.stb;
  assign link.host_tx_byte = s.tx_byte;
  assign link.grant = s.grant;
endmodule : hd_master

// ===== hd_node.sv
/*
  Network node: addressed slave with reply and check field, plus the
  network_command_function master with line sensing, token and grant
  gating, behind an Avalon-MM slave.
  Assumes the line interface and the far end share this clock.
*/
//
// Function
// - At most one line driver enabled.
// - Only master originates; slaves only reply.
// - Master enables driver before sending command.
// - Master releases line after last stop bit.
// - Slave answers only its own identifier.
// - Node identifiers distinct across network.
// - Common baud rate and character format.
// - Wait for idle line before sending.
// - Hand on reply only with good check.
// - Master checks reply id, header, length; the node master checks only length, terminator and check field.
// - Varied backoff then resend after bad reply; the node sets err with no resend, hd_master waits a fixed BACKOFF_CYC.
// - Token holder alone may issue commands.
// - Release command or fixed interval ends token.
// - Token passes down list, wraps to first.
// - Sequencer asserts one grant per slot.
// - Start commands only while grant asserted.
// - Reply: at-sign, id, header, data, check, terminator.
// - Bad command check gives framing error reply.
`timescale 1ns/100ps
module hd_node
  import hd_bus_pkg::*;
#(
  parameter logic [7:0] NODE_ID_RST = RST_NODE_ID,
  parameter int unsigned TIMEOUT_CYC = TIMEOUT_DEF
)(
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Avalon-MM slave
  input wire logic [2:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Network
  hd_link_if.dev link
);
  typedef struct packed {
    phase_t ph;
    logic [1:0] mode;
    logic [7:0] node_id;
    logic [7:0] tgt;
    logic [7:0] hdr;
    logic [7:0] arg;
    logic [7:0] data;
    logic [7:0] rep_id;
    logic [7:0] rep_hdr;
    logic [7:0] rep_data;
    logic token;
    logic busy;
    logic done;
    logic err;
    logic ferr;
    logic is_cmd;
    logic waitreq;
    logic oe_n;
    logic stb;
    logic [7:0] tx_byte;
    frame_t txb;
    frame_t rxb;
    logic [2:0] tx_idx;
    logic [2:0] rx_cnt;
    logic [7:0] idle_cnt;
    logic [31:0] tmo;
    logic [31:0] rdata;
  } node_t;

  localparam node_t NODE_RST = '{
    ph: PH_IDLE,
    mode: MODE_SENSE,
    node_id: NODE_ID_RST,
    waitreq: 1'b1,
    oe_n: 1'b1,
    default: '0
  };

  node_t s;
  node_t next_s;
  logic rx_full;
  logic fcs_ok;
  logic quiet;
  logic permit;
  logic [31:0] status_word;

  // Frame decode
  assign rx_full = (s.rx_cnt == FRAME_LEN) && (s.rxb[F_TERM] == CH_TERM);
  assign fcs_ok = fcs(CH_AT, s.rxb[F_ID], s.rxb[F_HDR], s.rxb[F_ARG]) == s.rxb[F_FCS];
  assign quiet = s.idle_cnt == IDLE_CYC;
  assign permit = (s.mode == MODE_SENSE) ||
                  (s.mode == MODE_TOKEN && s.token) ||
                  (s.mode == MODE_GRANT && link.grant);

  always_comb begin
    status_word = 32'h0;
    status_word[ST_BUSY] = s.busy;
    status_word[ST_DONE] = s.done;
    status_word[ST_ERR] = s.err;
    status_word[ST_TOKEN] = s.token;
    status_word[ST_FERR] = s.ferr;
  end

  always_comb begin
    next_s = s;
    next_s.stb = 1'b0;
    // Bus slave, one wait cycle
    next_s.waitreq = 1'b1;
    if ((read || write) && s.waitreq) begin
      next_s.waitreq = 1'b0;
      unique case (address)
        REG_CTRL: next_s.rdata = {30'h0, s.mode};
        REG_NODE_ID: next_s.rdata = {24'h0, s.node_id};
        REG_CMD: next_s.rdata = {8'h0, s.arg, s.hdr, s.tgt};
        REG_STATUS: next_s.rdata = status_word;
        REG_REPLY: next_s.rdata = {8'h0, s.rep_data, s.rep_hdr, s.rep_id};
        REG_DATA: next_s.rdata = {24'h0, s.data};
        default: next_s.rdata = 32'h0;
      endcase
    end
    if (write && !s.waitreq) begin
      unique case (address)
        REG_CTRL: begin
          next_s.mode = writedata[1:0];
          if (writedata[CTRL_GO] && !s.busy) begin
            next_s.busy = 1'b1;
            next_s.done = 1'b0;
            next_s.err = 1'b0;
            if (s.ph == PH_IDLE) next_s.ph = PH_ARB;
          end
        end
        REG_NODE_ID: next_s.node_id = writedata[7:0];
        REG_CMD: begin
          if (!s.busy) {next_s.arg, next_s.hdr, next_s.tgt} = writedata[23:0];
        end
        REG_STATUS: begin
          if (writedata[ST_DONE]) next_s.done = 1'b0;
          if (writedata[ST_ERR]) next_s.err = 1'b0;
          if (writedata[ST_FERR]) next_s.ferr = 1'b0;
        end
        REG_DATA: next_s.data = writedata[7:0];
        default: ;
      endcase
    end
    // Receive frames while not driving
    if (s.rx_cnt == FRAME_LEN) begin
      next_s.rx_cnt = 3'h0;
    end else if (link.line_stb && s.oe_n) begin
      if (s.rx_cnt == 3'h0) begin
        if (link.line_byte == CH_AT) next_s.rx_cnt = 3'h1;
      end else begin
        next_s.rxb[s.rx_cnt] = link.line_byte;
        next_s.rx_cnt = s.rx_cnt + 3'h1;
      end
    end
    // Line idle sense
    if (link.line_driven) begin
      next_s.idle_cnt = 8'h00;
    end else if (!quiet) begin
      next_s.idle_cnt = s.idle_cnt + 8'h01;
    end
    // Sequencing, events after clears so a set wins
    unique case (s.ph)
      PH_IDLE, PH_ARB: begin
        if (rx_full && s.rxb[F_ID] == s.node_id) begin
          if (!fcs_ok) begin
            next_s.ferr = 1'b1;
            next_s.txb = frame(s.node_id, HDR_FERR, s.rxb[F_HDR]);
          end else if (s.rxb[F_HDR] == HDR_TOKEN) begin
            next_s.token = s.rxb[F_ARG][0];
            next_s.txb = frame(s.node_id, HDR_TOKEN, s.rxb[F_ARG]);
          end else begin
            next_s.txb = frame(s.node_id, s.rxb[F_HDR], s.data);
          end
          next_s.is_cmd = 1'b0;
          next_s.oe_n = 1'b0;
          next_s.tx_idx = 3'h0;
          next_s.ph = PH_SEND;
        end else if (s.ph == PH_ARB && quiet && permit) begin
          next_s.txb = frame(s.tgt, s.hdr, s.arg);
          next_s.is_cmd = 1'b1;
          next_s.oe_n = 1'b0;
          next_s.tx_idx = 3'h0;
          next_s.ph = PH_SEND;
        end
      end
      PH_SEND: begin
        if (s.tx_idx != FRAME_LEN) begin
          next_s.stb = 1'b1;
          next_s.tx_byte = s.txb[s.tx_idx];
          next_s.tx_idx = s.tx_idx + 3'h1;
        end else begin
          next_s.oe_n = 1'b1;
          next_s.tmo = 32'(TIMEOUT_CYC);
          if (s.is_cmd) begin
            next_s.ph = PH_RWAIT;
          end else begin
            next_s.ph = s.busy ? PH_ARB : PH_IDLE;
          end
        end
      end
      PH_RWAIT: begin
        next_s.tmo = s.tmo - 32'h1;
        if (rx_full) begin
          next_s.busy = 1'b0;
          next_s.ph = PH_IDLE;
          if (fcs_ok) begin
            next_s.done = 1'b1;
            next_s.rep_id = s.rxb[F_ID];
            next_s.rep_hdr = s.rxb[F_HDR];
            next_s.rep_data = s.rxb[F_ARG];
            if (s.hdr == HDR_TOKEN && s.arg == 8'h00) next_s.token = 1'b0;
          end else begin
            next_s.err = 1'b1;
          end
        end else if (s.tmo == 32'h0) begin
          next_s.err = 1'b1;
          next_s.busy = 1'b0;
          next_s.ph = PH_IDLE;
        end
      end
      default: next_s.ph = PH_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      s <= NODE_RST;
    end else begin
      s <= next_s;
    end
  end

  // Outputs straight from state
  assign readdata = s.rdata;
  assign waitrequest = s.waitreq;
  assign link.dev_tx_oe_n = s.oe_n;
  assign link.dev_tx_stb = s.stb;
  assign link.dev_tx_byte = s.tx_byte;
endmodule : hd_node

// ===== testbench.sv
/*
  Bench joining node and master over one line.
  Assumes both Avalon slaves answer by lowering waitrequest; the master
  grants a token to two listed nodes in turn.
*/
`timescale 1ns/100ps
`define chk(n, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
  $display("mismatch %s exp %h seen %h", n, e, g); end end
module testbench
  import hd_bus_pkg::*;
;
  typedef struct packed {logic [7:0] hdr; logic [7:0] arg; logic [7:0] dat;} row_t;
  logic clock, sys_rst, nwq, mwq, early;
  logic [2:0] addr [2];
  logic rd [2];
  logic wr [2];
  logic [31:0] wd [2];
  logic [31:0] nq, mq, v;
  int bad_count, checked, n;
  row_t rows [3] = '{'{8'h52, 8'h00, 8'h5A}, '{8'h57, 8'hFF, 8'h00}, '{8'h40, 8'h40, 8'h40}};
  hd_link_if hd_link_if_i ();
  hd_node #(.TIMEOUT_CYC(64)) hd_node_i (.clock(clock), .sys_rst(sys_rst), .address(addr[0]),
    .read(rd[0]), .write(wr[0]), .writedata(wd[0]), .readdata(nq), .waitrequest(nwq), .link(hd_link_if_i));
  hd_master #(.NODES(2), .SLOT_CYC_P(200), .TIMEOUT_CYC(64), .BACKOFF_CYC(40)) hd_master_i (.clock(clock),
    .sys_rst(sys_rst), .address(addr[1]), .read(rd[1]), .write(wr[1]), .writedata(wd[1]),
    .readdata(mq), .waitrequest(mwq), .link(hd_link_if_i));
  hd_link_monitor hd_link_monitor_i (.clock(clock), .sys_rst(sys_rst),
    .dev_tx_oe_n(hd_link_if_i.dev_tx_oe_n), .dev_tx_stb(hd_link_if_i.dev_tx_stb),
    .dev_tx_byte(hd_link_if_i.dev_tx_byte), .host_tx_oe_n(hd_link_if_i.host_tx_oe_n),
    .host_tx_stb(hd_link_if_i.host_tx_stb), .host_tx_byte(hd_link_if_i.host_tx_byte),
    .grant(hd_link_if_i.grant), .line_driven(hd_link_if_i.line_driven));
  // Avalon cycle, slave 0 node, 1 master; read data lands in v
  task bus(input int s, input logic w, input logic [2:0] a, input logic [31:0] d);
    @(posedge clock);
    addr[s] <= a;
    wr[s] <= w;
    rd[s] <= !w;
    wd[s] <= d;
    do begin
      @(posedge clock);
    end while ((s ? mwq : nwq) !== 1'b0);
    v = s ? mq : nq;
    wr[s] <= 1'b0;
    rd[s] <= 1'b0;
  endtask : bus
  task wait_bit(input int s, input logic [2:0] a, input int b);
    int k;
    k = 0;
    do begin
      bus(s, 1'b0, a, 32'h0);
      k++;
    end while (v[b] !== 1'b1 && k < 400);
  endtask : wait_bit
  task results;
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : results
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  initial begin
    #(4 * 40000);
    bad_count++;
    results;
  end
  initial begin
    sys_rst = 1'b1;
    addr = '{3'h0, 3'h0};
    rd = '{1'b0, 1'b0};
    wr = '{1'b0, 1'b0};
    wd = '{32'h0, 32'h0};
    bad_count = 0;
    checked = 0;
    repeat (6) @(posedge clock);
    sys_rst <= 1'b0;
    @(negedge clock);
    `chk("dev oe_n", 1'b1, hd_link_if_i.dev_tx_oe_n)
    `chk("host oe_n", 1'b1, hd_link_if_i.host_tx_oe_n)
    bus(0, 1'b0, REG_NODE_ID, 32'h0);
    `chk("node id", 32'h01, v)
    bus(0, 1'b1, 3'h7, 32'h5);
    bus(0, 1'b0, 3'h7, 32'h0);
    `chk("unmapped", 32'h0, v)
    $display("test reset done");
    foreach (rows[i]) begin
      bus(0, 1'b1, REG_DATA, {24'h0, rows[i].dat});
      bus(1, 1'b1, HREG_CMD, {8'h0, rows[i].arg, rows[i].hdr, 8'h01});
      wait_bit(1, HREG_STATUS, ST_DONE);
      `chk("master status", 3'b010, v[2:0])
      bus(1, 0, HREG_REPLY, 32'h0);
      `chk("reply", {8'h0, rows[i].dat, rows[i].hdr, 8'h01}, v)
      bus(1, 1'b1, HREG_STATUS, 32'h27);
    end
    $display("test rows done");
    bus(1, 1'b1, HREG_CMD, {8'h0, 8'h11, 8'h52, 8'h07});
    wait_bit(1, HREG_STATUS, ST_ERR);
    `chk("silent", 1'b0, v[ST_DONE])
    `chk("tries", 1'b1, v[15:8] != 8'h00)
    bus(1, 1'b1, HREG_CMD, {8'h0, 8'h11, 8'h52, 8'h08});
    bus(1, 1'b0, HREG_STATUS, 32'h0);
    `chk("refused", 1'b1, v[ST_REFUSED])
    bus(0, 1'b1, REG_NODE_ID, 32'h07);
    wait_bit(1, HREG_STATUS, ST_DONE);
    bus(1, 1'b0, HREG_REPLY, 32'h0);
    `chk("retry reply", {8'h0, 8'h40, 8'h52, 8'h07}, v)
    bus(0, 1'b1, REG_NODE_ID, 32'h01);
    bus(1, 1'b1, HREG_STATUS, 32'h27);
    $display("test retry done");
    bus(0, 1'b1, REG_CTRL, {24'h0, 6'h0, MODE_TOKEN});
    bus(1, 1'b1, HREG_CTRL, {24'h0, 6'h0, MODE_TOKEN});
    wait_bit(1, HREG_STATUS, ST_TOKEN);
    `chk("token out", 1'b1, v[ST_TOKEN])
    `chk("first slot", 8'h00, v[23:16])
    bus(0, 1'b0, REG_STATUS, 32'h0);
    `chk("token held", 1'b1, v[ST_TOKEN])
    bus(0, 1'b1, REG_CMD, {8'h0, 8'h00, HDR_TOKEN, RST_HOST_ID});
    bus(0, 1'b1, REG_CTRL, 32'h101);
    wait_bit(0, REG_STATUS, ST_DONE);
    `chk("released", 1'b0, v[ST_TOKEN])
    bus(1, 1'b0, HREG_STATUS, 32'h0);
    `chk("next slot", 8'h01, v[23:16])
    bus(0, 1'b1, REG_NODE_ID, 32'h02);
    wait_bit(0, REG_STATUS, ST_TOKEN);
    bus(1, 1'b1, HREG_CTRL, 32'h11);
    n = 0;
    do begin
      bus(0, 1'b0, REG_STATUS, 32'h0);
      n++;
    end while (v[ST_TOKEN] !== 1'b0 && n < 400);
    `chk("revoked", 1'b0, v[ST_TOKEN])
    bus(0, 1'b1, REG_NODE_ID, 32'h01);
    wait_bit(0, REG_STATUS, ST_TOKEN);
    bus(1, 1'b0, HREG_STATUS, 32'h0);
    `chk("wrapped slot", 8'h00, v[23:16])
    $display("test token done");
    bus(1, 1'b1, HREG_CTRL, {24'h0, 6'h0, MODE_GRANT});
    bus(0, 1'b1, REG_CTRL, {24'h0, 6'h0, MODE_GRANT});
    bus(0, 1'b1, REG_STATUS, 32'h17);
    n = 0;
    while (hd_link_if_i.grant !== 1'b0 && n < 1000) begin
      @(negedge clock);
      n++;
    end
    bus(0, 1'b1, REG_CMD, {8'h0, 8'h33, 8'h52, RST_HOST_ID});
    bus(0, 1'b1, REG_CTRL, 32'h102);
    early = 1'b0;
    n = 0;
    while (hd_link_if_i.grant !== 1'b1 && n < 1000) begin
      @(negedge clock);
      early = early | !hd_link_if_i.dev_tx_oe_n;
      n++;
    end
    `chk("no start without grant", 1'b0, early)
    n = 0;
    while (hd_link_if_i.dev_tx_oe_n !== 1'b0 && n < 300) begin
      @(negedge clock);
      n++;
    end
    `chk("grant at start", 1'b1, hd_link_if_i.grant)
    wait_bit(0, REG_STATUS, ST_ERR);
    `chk("missing reply", 1'b0, v[ST_DONE])
    $display("test grant done");
    results;
  end
endmodule : testbench
